// File: ppr_core.sv
// Host register core of a PC-compatible printer port.
// Assumes host strobes come from logic on clk_sys; pins are asynchronous.
`default_nettype none

module ppr_core #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Configuration
    input wire logic [ADDR_W-1:0] base_address,
    input wire logic [1:0] port_mode,
    input wire logic timeout_clear_select,
    // Host I/O access
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [DATA_W-1:0] io_wdata,
    output logic [DATA_W-1:0] io_rdata,
    output logic io_ready,
    output logic port_irq,
    // Parallel data pins
    input wire logic [DATA_W-1:0] parallel_data_pins_in,
    output logic [DATA_W-1:0] parallel_data_pins_out,
    output logic parallel_data_pins_oe,
    // Peripheral status inputs
    input wire logic fault_input_pin,
    input wire logic online_input_level,
    input wire logic paper_out_level,
    input wire logic acknowledge_input,
    input wire logic busy_pin,
    // Peripheral control outputs
    output logic strobe_pin,
    output logic line_feed_pin,
    output logic initialize_pin,
    output logic select_in_pin
);

    typedef struct packed {
        logic [DATA_W-1:0] data_reg;
        logic [ppr_pkg::CT_WIDTH-1:0] ctrl;
        logic cycle_timeout_flag;
        logic [DATA_W-1:0] epp_out;
        logic [DATA_W-1:0] epp_in;
        ppr_pkg::ppr_epp_e epp_state;
        logic epp_read;
        logic [ppr_pkg::TMO_CNT_W-1:0] epp_cnt;
        logic [DATA_W-1:0] status_hold;
        logic [DATA_W-1:0] rdata;
        logic rd_q;
        logic wr_q;
        logic status_read;
        logic ack_q;
        logic irq;
    } ppr_core_s;

    ppr_core_s state;
    ppr_core_s next_state;

    logic [DATA_W-1:0] pins_sync;
    logic [4:0] stat_sync;
    logic fault_level;
    logic online_level;
    logic paper_level;
    logic ack_level;
    logic busy_level;
    logic [DATA_W-1:0] status_now;
    logic hit;
    logic [2:0] offset;
    logic rd_start;
    logic rd_end;
    logic wr_start;
    logic epp_mode;
    logic printer_mode;

    // Pin inputs pass two flip-flops first
    ppr_sync #(
        .WIDTH(DATA_W)
    ) u_sync_data (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(parallel_data_pins_in),
        .sync_out(pins_sync)
    );

    ppr_sync #(
        .WIDTH(5)
    ) u_sync_status (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({busy_pin, acknowledge_input, paper_out_level, online_input_level,
                   fault_input_pin}),
        .sync_out(stat_sync)
    );

    assign fault_level = stat_sync[0];
    assign online_level = stat_sync[1];
    assign paper_level = stat_sync[2];
    assign ack_level = stat_sync[3];
    assign busy_level = stat_sync[4];

    // Window decode, shared by reads and writes
    function automatic logic decode_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base,
        input logic is_epp
    );
        logic [ADDR_W-1:0] diff;
        logic in_window;
        diff = addr - base;
        in_window = (addr >= base) && (diff < ADDR_W'(ppr_pkg::WINDOW_SIZE));
        if (!in_window) begin
            decode_hit = 1'b0;
        end else if (diff[2:0] <= ppr_pkg::OFF_CONTROL) begin
            decode_hit = 1'b1;
        end else begin
            decode_hit = is_epp;
        end
    endfunction

    assign epp_mode = (port_mode == ppr_pkg::PPR_MODE_EPP);
    assign printer_mode = (port_mode == ppr_pkg::PPR_MODE_PRINTER);
    assign offset = 3'(io_addr - base_address);
    assign hit = decode_hit(io_addr, base_address, epp_mode);
    assign rd_start = io_rd && !state.rd_q;
    assign rd_end = !io_rd && state.rd_q;
    assign wr_start = io_wr && !state.wr_q;

    // Live status byte
    assign status_now = {~busy_level, ack_level, paper_level, online_level,
                         fault_level, ppr_pkg::ZERO_PAIR,
                         state.cycle_timeout_flag};

    always_comb begin
        logic clear_tmo;
        logic set_tmo;
        clear_tmo = 1'b0;
        set_tmo = 1'b0;
        next_state = state;
        next_state.rd_q = io_rd;
        next_state.wr_q = io_wr;
        next_state.ack_q = ack_level;

        // Interrupt on rising acknowledge, held off when disabled
        next_state.irq = state.ctrl[ppr_pkg::CT_IRQ_EN] && ack_level && !state.ack_q;

        // Host writes
        if (wr_start && hit) begin
            if (offset == ppr_pkg::OFF_DATA) begin
                next_state.data_reg = io_wdata;
            end else if (offset == ppr_pkg::OFF_STATUS) begin
                if (!timeout_clear_select && io_wdata[ppr_pkg::ST_TIMEOUT]) begin
                    clear_tmo = 1'b1;
                end
            end else if (offset == ppr_pkg::OFF_CONTROL) begin
                next_state.ctrl = io_wdata[ppr_pkg::CT_WIDTH-1:0];
            end else if (state.epp_state == ppr_pkg::PPR_EPP_IDLE) begin
                next_state.epp_out = io_wdata;
                next_state.epp_read = 1'b0;
                next_state.epp_state = ppr_pkg::PPR_EPP_WAIT_LOW;
                next_state.epp_cnt = ppr_pkg::TMO_ZERO;
            end
        end

        // Host reads
        if (rd_start && hit) begin
            if (offset == ppr_pkg::OFF_STATUS) begin
                next_state.status_hold = status_now;
                next_state.status_read = 1'b1;
            end else if (offset >= ppr_pkg::OFF_EPP_ADDR &&
                         state.epp_state == ppr_pkg::PPR_EPP_IDLE) begin
                next_state.epp_read = 1'b1;
                next_state.epp_state = ppr_pkg::PPR_EPP_WAIT_LOW;
                next_state.epp_cnt = ppr_pkg::TMO_ZERO;
            end
        end

        // Read data: data pins pass through, status stays held
        if (io_rd && hit) begin
            if (offset == ppr_pkg::OFF_DATA) begin
                next_state.rdata = pins_sync;
            end else if (offset == ppr_pkg::OFF_STATUS) begin
                next_state.rdata = rd_start ? status_now : state.status_hold;
            end else if (offset == ppr_pkg::OFF_CONTROL) begin
                next_state.rdata = {ppr_pkg::ZERO_PAIR, state.ctrl};
            end else begin
                next_state.rdata = state.epp_in;
            end
        end else if (!io_rd) begin
            next_state.rdata = state.rdata;
        end else begin
            next_state.rdata = '0;
        end

        // Trailing edge of a status read
        if (rd_end && state.status_read) begin
            next_state.status_read = 1'b0;
            if (timeout_clear_select) begin
                clear_tmo = 1'b1;
            end
        end

        // EPP cycle watchdog: wait must go low, then high
        case (state.epp_state)
            ppr_pkg::PPR_EPP_IDLE: begin
                next_state.epp_cnt = ppr_pkg::TMO_ZERO;
            end
            ppr_pkg::PPR_EPP_WAIT_LOW: begin
                next_state.epp_cnt = state.epp_cnt + ppr_pkg::TMO_ONE;
                if (state.epp_cnt >= ppr_pkg::TMO_LIMIT) begin
                    set_tmo = 1'b1;
                    next_state.epp_state = ppr_pkg::PPR_EPP_IDLE;
                end else if (!busy_level) begin
                    next_state.epp_state = ppr_pkg::PPR_EPP_WAIT_HIGH;
                end
            end
            ppr_pkg::PPR_EPP_WAIT_HIGH: begin
                next_state.epp_cnt = state.epp_cnt + ppr_pkg::TMO_ONE;
                if (state.epp_cnt >= ppr_pkg::TMO_LIMIT) begin
                    set_tmo = 1'b1;
                    next_state.epp_state = ppr_pkg::PPR_EPP_IDLE;
                end else if (busy_level) begin
                    if (state.epp_read) begin
                        next_state.epp_in = pins_sync;
                    end
                    next_state.epp_state = ppr_pkg::PPR_EPP_IDLE;
                end
            end
            default: begin
                next_state.epp_state = ppr_pkg::PPR_EPP_IDLE;
            end
        endcase

        // Leaving EPP mode abandons any cycle
        if (!epp_mode) begin
            next_state.epp_state = ppr_pkg::PPR_EPP_IDLE;
        end

        // Set wins over clear
        if (set_tmo) begin
            next_state.cycle_timeout_flag = 1'b1;
        end else if (clear_tmo) begin
            next_state.cycle_timeout_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state.data_reg <= ppr_pkg::DATA_RESET;
            state.ctrl <= ppr_pkg::CONTROL_RESET;
            state.cycle_timeout_flag <= 1'b0;
            state.epp_out <= ppr_pkg::EPP_RESET;
            state.epp_in <= ppr_pkg::EPP_RESET;
            state.epp_state <= ppr_pkg::PPR_EPP_IDLE;
            state.epp_read <= 1'b0;
            state.epp_cnt <= ppr_pkg::TMO_ZERO;
            state.status_hold <= '0;
            state.rdata <= '0;
            state.rd_q <= 1'b0;
            state.wr_q <= 1'b0;
            state.status_read <= 1'b0;
            state.ack_q <= 1'b0;
            state.irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Host outputs
    assign io_rdata = state.rdata;
    assign io_ready = (state.epp_state == ppr_pkg::PPR_EPP_IDLE);
    assign port_irq = state.irq;

    // Data pins: EPP cycle data overrides the data register
    assign parallel_data_pins_out = (state.epp_state != ppr_pkg::PPR_EPP_IDLE)
                                    ? state.epp_out : state.data_reg;
    assign parallel_data_pins_oe = printer_mode ||
                                   (!state.ctrl[ppr_pkg::CT_DIR] &&
                                    !((state.epp_state != ppr_pkg::PPR_EPP_IDLE) &&
                                      state.epp_read));

    // Control pins
    assign strobe_pin = ~state.ctrl[ppr_pkg::CT_STROBE];
    assign line_feed_pin = ~state.ctrl[ppr_pkg::CT_LINEFEED];
    assign initialize_pin = state.ctrl[ppr_pkg::CT_INIT];
    assign select_in_pin = ~state.ctrl[ppr_pkg::CT_SELIN];

endmodule // ppr_core

`default_nettype wire

// File: ppr_core_props.sv
// Concurrent checks on the printer port register core ports.
// Assumes one clk_sys domain with synchronous active-high sys_rst.
`default_nettype none
module ppr_core_props #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Host side
    input wire logic [ADDR_W-1:0] base_address,
    input wire logic [1:0] port_mode,
    input wire logic [ADDR_W-1:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic [DATA_W-1:0] io_rdata,
    input wire logic io_ready,
    input wire logic port_irq,
    // Pin side
    input wire logic acknowledge_input,
    input wire logic [DATA_W-1:0] parallel_data_pins_out,
    input wire logic parallel_data_pins_oe,
    input wire logic strobe_pin,
    input wire logic line_feed_pin,
    input wire logic initialize_pin,
    input wire logic select_in_pin
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic [ADDR_W-1:0] off;
    logic [3:0] wctl;
    logic [11:0] low_cnt;
    assign off = io_addr - base_address;
    assign wctl = io_wdata[3:0] ^ 4'hb;
    // Cycles spent with the host held off
    always_ff @(posedge clk_sys) begin
        if (sys_rst || io_ready) begin
            low_cnt <= 12'h000;
        end else if (low_cnt != 12'hfff) begin
            low_cnt <= low_cnt + 12'h001;
        end
    end
    property p_rst;
        disable iff (1'b0) sys_rst |=> parallel_data_pins_out == '0 && strobe_pin
            && line_feed_pin && !initialize_pin && select_in_pin && !port_irq;
    endproperty
    property p_data;
        $rose(io_wr) && off == '0 |=> parallel_data_pins_out == $past(io_wdata);
    endproperty
    property p_ctl;
        $rose(io_wr) && off == 2 |=>
            {select_in_pin, initialize_pin, line_feed_pin, strobe_pin} == $past(wctl);
    endproperty
    property p_st;
        $rose(io_rd) && off == 1 |-> ##2 io_rdata[2:1] == 2'h0;
    endproperty
    property p_ctlrd;
        $rose(io_rd) && off == 2 |-> ##2 io_rdata[7:6] == 2'h0;
    endproperty
    property p_hold;
        (io_rd && off == 1)[*4] |-> $stable(io_rdata);
    endproperty
    property p_refuse;
        $rose(io_rd) && port_mode != 2'h2 && off >= 3 |-> ##2 io_rdata == '0 && io_ready;
    endproperty
    property p_ready;
        $fell(io_ready) |-> $past(port_mode) == 2'h2;
    endproperty
    property p_tmo;
        !io_ready |-> low_cnt < ppr_pkg::TMO_LIMIT + 12'h010;
    endproperty
    property p_irq;
        port_irq |-> $past(acknowledge_input, 3) && !$past(acknowledge_input, 4)
            && !$past(port_irq);
    endproperty
    property p_oe;
        (port_mode == 2'h0)[*3] |-> parallel_data_pins_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_data: assert property (p_data) else $error("data pins wrong");
    a_ctl: assert property (p_ctl) else $error("control pins wrong");
    a_st: assert property (p_st) else $error("status bits 2:1 set");
    a_ctlrd: assert property (p_ctlrd) else $error("control bits 7:6 set");
    a_hold: assert property (p_hold) else $error("status moved in read");
    a_refuse: assert property (p_refuse) else $error("refused read answered");
    a_ready: assert property (p_ready) else $error("cycle outside mode");
    a_tmo: assert property (p_tmo) else $error("cycle not aborted");
    a_irq: assert property (p_irq) else $error("stray interrupt");
    a_oe: assert property (p_oe) else $error("pins not driven");
    c_irq: cover property (port_irq);
    c_end: cover property ($rose(io_ready));
    c_tmo: cover property (low_cnt == ppr_pkg::TMO_LIMIT);
endmodule // ppr_core_props
bind ppr_core ppr_core_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .base_address(base_address),
    .port_mode(port_mode), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ready(io_ready), .port_irq(port_irq),
    .acknowledge_input(acknowledge_input), .parallel_data_pins_out(parallel_data_pins_out),
    .parallel_data_pins_oe(parallel_data_pins_oe), .strobe_pin(strobe_pin),
    .line_feed_pin(line_feed_pin), .initialize_pin(initialize_pin),
    .select_in_pin(select_in_pin)
);
`default_nettype wire

// File: ppr_periph_model.sv
// Behavioural printer-side peripheral for the port register core bench.
// Assumes the bench hands it the cycle-active level and the host pin drive.
`default_nettype none
module ppr_periph_model (
    // Clock
    input wire logic clk_sys,
    // Bench control
    input wire logic cyc,
    input wire logic respond,
    input wire logic busy_lvl,
    input wire logic [7:0] drv,
    // Host pin drive
    input wire logic [7:0] out_val,
    input wire logic oe,
    // Levels seen by the host
    output logic [7:0] pins,
    output logic busy_pin
);
    logic [3:0] n;
    // Host wins the wire while it drives
    assign pins = oe ? out_val : drv;
    always_ff @(posedge clk_sys) begin
        if (!cyc) begin
            n <= 4'h0;
        end else if (n != 4'hf) begin
            n <= n + 4'h1;
        end
    end
    // Wait low for a while then released; a silent peripheral never answers
    assign busy_pin = cyc ? !(respond && n >= 4'h2 && n < 4'h6) : busy_lvl;
endmodule // ppr_periph_model
`default_nettype wire

// File: ppr_pkg.sv
// Package of constants for the printer port register core.
// Assumes a 200 MHz system clock and byte-wide host I/O accesses.
`default_nettype none

package ppr_pkg;

    // Register offsets from the base address
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_STATUS = 3'h1;
    localparam logic [2:0] OFF_CONTROL = 3'h2;
    localparam logic [2:0] OFF_EPP_ADDR = 3'h3;
    localparam logic [2:0] OFF_EPP_DATA0 = 3'h4;
    localparam logic [2:0] OFF_EPP_DATA3 = 3'h7;

    // Number of decoded byte addresses
    localparam logic [15:0] WINDOW_SIZE = 16'h0008;

    // Status bit positions
    localparam int ST_TIMEOUT = 0;

    // Control bit positions
    localparam int CT_STROBE = 0;
    localparam int CT_LINEFEED = 1;
    localparam int CT_INIT = 2;
    localparam int CT_SELIN = 3;
    localparam int CT_IRQ_EN = 4;
    localparam int CT_DIR = 5;
    localparam int CT_WIDTH = 6;

    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [7:0] EPP_RESET = 8'h00;
    localparam logic [1:0] ZERO_PAIR = 2'h0;

    // Port modes, as set by configuration
    typedef enum logic [1:0] {
        PPR_MODE_PRINTER = 2'h0,
        PPR_MODE_BIDIR = 2'h1,
        PPR_MODE_EPP = 2'h2,
        PPR_MODE_ECP = 2'h3
    } ppr_mode_e;

    // EPP cycle states
    typedef enum logic [2:0] {
        PPR_EPP_IDLE = 3'b001,
        PPR_EPP_WAIT_LOW = 3'b010,
        PPR_EPP_WAIT_HIGH = 3'b100
    } ppr_epp_e;

    // Watchdog timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int EPP_TIMEOUT_NS = 10000;
    localparam int EPP_TIMEOUT_CYC = (EPP_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    localparam int TMO_CNT_W = 12;
    localparam logic [TMO_CNT_W-1:0] TMO_LIMIT = TMO_CNT_W'(EPP_TIMEOUT_CYC);
    localparam logic [TMO_CNT_W-1:0] TMO_ZERO = 12'h000;
    localparam logic [TMO_CNT_W-1:0] TMO_ONE = 12'h001;

endpackage : ppr_pkg

`default_nettype wire

// File: ppr_sync.sv
// Two flip-flop synchroniser bank for the peripheral pin inputs.
// Assumes the inputs are asynchronous to clk_sys.
`default_nettype none

module ppr_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Asynchronous input and synchronised output
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } ppr_sync_s;

    ppr_sync_s state;
    ppr_sync_s next_state;

    always_comb begin
        next_state.first = async_in;
        next_state.second = state.first;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;

endmodule // ppr_sync

`default_nettype wire

// File: test_printer_port_register_core.sv
// Self-checking bench for the printer port register core.
// Assumes ppr_core, the peripheral model and the checker are compiled first.
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_printer_port_register_core;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] BASE = 16'h0378;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] port_mode = 2'h0;
    logic tsel = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] drv = 8'h3c;
    logic [7:0] io_rdata, pins_in, pins_out;
    logic io_ready, port_irq, oe, strobe, lf, init, selin, busy;
    logic fault = 1'b1, online = 1'b1, paper = 1'b0, ack = 1'b0;
    logic busy_lvl = 1'b0, respond = 1'b1;
    int fails = 0;
    int cmp_count = 0;
    ppr_core uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .base_address(BASE),
        .port_mode(port_mode), .timeout_clear_select(tsel), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_ready(io_ready), .port_irq(port_irq), .parallel_data_pins_in(pins_in),
        .parallel_data_pins_out(pins_out), .parallel_data_pins_oe(oe),
        .fault_input_pin(fault), .online_input_level(online), .paper_out_level(paper),
        .acknowledge_input(ack), .busy_pin(busy), .strobe_pin(strobe),
        .line_feed_pin(lf), .initialize_pin(init), .select_in_pin(selin));
    ppr_periph_model u_periph (.clk_sys(clk_sys), .cyc(!io_ready), .respond(respond),
        .busy_lvl(busy_lvl), .drv(drv), .out_val(pins_out), .oe(oe), .pins(pins_in),
        .busy_pin(busy));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("Mismatches %0d of %0d comparisons", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] off, input logic [7:0] d);
        @(posedge clk_sys) #1;
        io_addr = BASE + off;
        io_wdata = d;
        io_wr = 1'b1;
        repeat (2) @(posedge clk_sys) #1;
        io_wr = 1'b0;
    endtask
    task automatic rdc(input logic [15:0] off, input logic [7:0] exp);
        @(posedge clk_sys) #1;
        io_addr = BASE + off;
        io_rd = 1'b1;
        repeat (4) @(posedge clk_sys) #1;
        `CHK(io_rdata, exp)
        io_rd = 1'b0;
    endtask
    task automatic wait_rdy();
        for (int i = 0; i < 2200 && io_ready !== 1'b1; i++) @(posedge clk_sys) #1;
        if (io_ready !== 1'b1) begin
            fails++;
            test_done();
        end
    endtask
    task automatic ack_edge(input int exp);
        int n;
        n = 0;
        ack = 1'b0;
        repeat (6) @(posedge clk_sys) #1;
        ack = 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys) #1;
            n += int'(port_irq === 1'b1);
        end
        `CHK(n, exp)
    endtask
    function automatic logic [7:0] st(input logic f);
        return {~busy_lvl, ack, paper, online, fault, 2'b00, f};
    endfunction
    initial begin
        repeat (8) @(posedge clk_sys) #1;
        sys_rst = 1'b0;
        `CHK({pins_out, strobe, lf, init, selin}, 12'h00d)
        rdc(16'h0002, 8'h00);
        wr(16'h0000, 8'ha5);
        `CHK(pins_out, 8'ha5)
        wr(16'h0002, 8'h20);
        `CHK(oe, 1'b1)
        rdc(16'h0000, 8'ha5);
        port_mode = 2'h1;
        repeat (3) @(posedge clk_sys) #1;
        `CHK(oe, 1'b0)
        rdc(16'h0000, 8'h3c);
        wr(16'h0002, 8'hff);
        rdc(16'h0002, 8'h3f);
        wr(16'h0002, 8'h05);
        `CHK({strobe, lf, init, selin}, 4'h7)
        for (int k = 0; k < 2; k++) begin
            {fault, online, paper, ack, busy_lvl} = k ? 5'h0b : 5'h14;
            repeat (4) @(posedge clk_sys) #1;
            rdc(16'h0001, st(1'b0));
        end
        fork
            rdc(16'h0001, st(1'b0));
            begin
                repeat (2) @(posedge clk_sys) #1;
                fault = ~fault;
            end
        join
        rdc(16'h0003, 8'h00);
        rdc(16'h0008, 8'h00);
        wr(16'h0008, 8'h77);
        `CHK(pins_out, 8'ha5)
        wr(16'h0002, 8'h15);
        ack_edge(1);
        wr(16'h0002, 8'h05);
        ack_edge(0);
        port_mode = 2'h2;
        busy_lvl = 1'b1;
        wr(16'h0004, 8'h5a);
        wait_rdy();
        rdc(16'h0001, st(1'b0));
        rdc(16'h0002, 8'h05);
        respond = 1'b0;
        wr(16'h0003, 8'h11);
        wait_rdy();
        rdc(16'h0001, st(1'b1));
        wr(16'h0001, 8'h00);
        rdc(16'h0001, st(1'b1));
        wr(16'h0001, 8'h01);
        rdc(16'h0001, st(1'b0));
        wr(16'h0004, 8'h22);
        wait_rdy();
        tsel = 1'b1;
        rdc(16'h0001, st(1'b1));
        rdc(16'h0001, st(1'b0));
        respond = 1'b1;
        drv = 8'h96;
        rdc(16'h0004, 8'h00);
        `CHK(oe, 1'b0)
        wait_rdy();
        rdc(16'h0004, 8'h96);
        wait_rdy();
        port_mode = 2'h3;
        `CHK(oe, 1'b1)
        rdc(16'h0004, 8'h00);
        wr(16'h0000, 8'hc3);
        sys_rst = 1'b1;
        repeat (3) @(posedge clk_sys) #1;
        sys_rst = 1'b0;
        `CHK(pins_out, 8'h00)
        test_done();
    end
endmodule // test_printer_port_register_core
`default_nettype wire
